// ==== logic/fps_defs.svh ====
// Functional notes
// - Keys 55h then AAh back to back arm the trigger; nothing else does.
// - Unlock key register is write-only and always reads zero.
// - Processor stays stalled while an operation runs, released at its end.
// - Setting control bit 15 starts the operation; hardware clears it at end.
// - Software cannot clear the trigger; the operation is self-timed.
// - Write-enable bit 14 permits operations; cleared, every trigger is inhibited.
// - Error flag bit 13 set on improper attempt or early termination.
// - Erase-select bit 6 chooses erase by code, else program.
// - Codes 1010xx and 1001xx erase boot or all, serial mode only.
// - Codes 011010, 011001, 011000 erase four, two, one rows.
// - Codes 0101xx config, 0100xx data EEPROM, 0011xx general block erase.
// - With erase-select clear, code 0001xx writes one row from buffers.
// - Any other code performs no operation when triggered.
// - Row erases use table pointer formed from page and effective address.
// - Program-only bit 12 is stored but ignored for flash operations.
// - After the key pair only the next register write may set trigger.
// - Table writes stay in holding latches until a program is triggered.
`ifndef FPS_DEFS_SVH
`define FPS_DEFS_SVH

// ==========================================================
// Register offsets
`define FPS_ADDR_W         8
`define FPS_OFS_CONTROL    8'h00
`define FPS_OFS_KEY        8'h04
`define FPS_OFS_PAGE       8'h08
`define FPS_OFS_EA         8'h0C
`define FPS_OFS_LATCH_LO   8'h10
`define FPS_OFS_LATCH_HI   8'h14

// ==========================================================
// Control fields
`define FPS_BIT_WR         15
`define FPS_BIT_WEN        14
`define FPS_BIT_ERR        13
`define FPS_BIT_PROG_ONLY  12
`define FPS_BIT_ERASE      6
`define FPS_CTL_RESET      16'h0000
`define FPS_KEY_FIRST      8'h55
`define FPS_KEY_SECOND     8'hAA

// ==========================================================
// Row geometry
`define FPS_ROW_WORDS      32
`define FPS_ROW1_MASK      24'hFFFFC0
`define FPS_ROW2_MASK      24'hFFFF80
`define FPS_ROW4_MASK      24'hFFFF00

// ==========================================================
// Timing
`define FPS_CLK_PERIOD_NS  40
`define FPS_ERASE_TIME_NS  20000
`define FPS_PROG_TIME_NS   4000
`define FPS_ERASE_CYC \
  ((`FPS_ERASE_TIME_NS + `FPS_CLK_PERIOD_NS - 1) / `FPS_CLK_PERIOD_NS)
`define FPS_PROG_CYC \
  ((`FPS_PROG_TIME_NS + `FPS_CLK_PERIOD_NS - 1) / `FPS_CLK_PERIOD_NS)

`endif

// ==== logic/fps_pkg.sv ====
package fps_pkg;

  typedef enum logic [3:0] {
    FPS_OP_NONE,
    FPS_OP_DENIED,
    FPS_OP_ERASE_BOOT,
    FPS_OP_ERASE_ALL,
    FPS_OP_ERASE_ROW1,
    FPS_OP_ERASE_ROW2,
    FPS_OP_ERASE_ROW4,
    FPS_OP_ERASE_CFG,
    FPS_OP_ERASE_EE,
    FPS_OP_ERASE_GEN,
    FPS_OP_WRITE_ROW
  } fps_op_type;

  typedef enum logic [1:0] {
    FPS_KEY_LOCKED,
    FPS_KEY_HALF,
    FPS_KEY_OPEN
  } fps_key_type;

  typedef enum logic {
    FPS_ENG_IDLE,
    FPS_ENG_RUN
  } fps_eng_type;

endpackage

// ==== logic/fps_op_if.sv ====
`timescale 1ns/10ps
interface fps_op_if;
  logic       start;
  logic       erase;
  logic       abort;
  logic       busy;
  logic       done;
  logic       aborted;
  logic       word_req;
  logic [4:0] word_idx;

  modport seq (
    output start, erase, abort,
    input  busy, done, aborted, word_req, word_idx
  );
  modport engine (
    input  start, erase, abort,
    output busy, done, aborted, word_req, word_idx
  );
endinterface

// ==== logic/fps_op_engine.sv ====
`timescale 1ns/10ps
`include "fps_defs.svh"
module fps_op_engine (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Sequencer side
  fps_op_if.engine op
);

  fps_pkg::fps_eng_type st_r, st_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [5:0]  wcnt_r, wcnt_nxt;
  logic        done_r, done_nxt;
  logic        abt_r, abt_nxt;
  logic        req_r, req_nxt;
  logic [4:0]  idx_r, idx_nxt;

  // ==========================================================
  // Self-timed operation
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    wcnt_nxt = wcnt_r;
    done_nxt = 1'b0;
    abt_nxt  = 1'b0;
    req_nxt  = 1'b0;
    idx_nxt  = idx_r;
    unique case (st_r)
      fps_pkg::FPS_ENG_IDLE: begin
        if (op.start) begin
          st_nxt = fps_pkg::FPS_ENG_RUN;
          if (op.erase) begin
            cnt_nxt  = 16'(`FPS_ERASE_CYC);
            wcnt_nxt = 6'(`FPS_ROW_WORDS);
          end else begin
            cnt_nxt  = 16'(`FPS_PROG_CYC);
            wcnt_nxt = 6'h00;
          end
        end
      end
      fps_pkg::FPS_ENG_RUN: begin
        if (op.abort) begin
          st_nxt  = fps_pkg::FPS_ENG_IDLE;
          abt_nxt = 1'b1;
        end else if (cnt_r == 16'h0001) begin
          st_nxt   = fps_pkg::FPS_ENG_IDLE;
          done_nxt = 1'b1;
        end
        cnt_nxt = cnt_r - 16'h0001;
        if (wcnt_r < 6'(`FPS_ROW_WORDS) && !op.abort) begin
          req_nxt  = 1'b1;
          idx_nxt  = wcnt_r[4:0];
          wcnt_nxt = wcnt_r + 6'h01;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r   <= fps_pkg::FPS_ENG_IDLE;
      cnt_r  <= 16'h0000;
      wcnt_r <= 6'h00;
      done_r <= 1'b0;
      abt_r  <= 1'b0;
      req_r  <= 1'b0;
      idx_r  <= 5'h00;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      wcnt_r <= wcnt_nxt;
      done_r <= done_nxt;
      abt_r  <= abt_nxt;
      req_r  <= req_nxt;
      idx_r  <= idx_nxt;
    end
  end

  assign op.busy     = (st_r == fps_pkg::FPS_ENG_RUN);
  assign op.done     = done_r;
  assign op.aborted  = abt_r;
  assign op.word_req = req_r;
  assign op.word_idx = idx_r;

endmodule

// ==== logic/fps_flash_seq.sv ====
`timescale 1ns/10ps
`include "fps_defs.svh"
module fps_flash_seq (
  // Clock and reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // AXI4-Lite write address
  input  wire logic                     awvalid,
  output wire logic                     awready,
  input  wire logic [`FPS_ADDR_W-1:0]   awaddr,
  input  wire logic [2:0]               awprot,
  // AXI4-Lite write data
  input  wire logic                     wvalid,
  output wire logic                     wready,
  input  wire logic [31:0]              wdata,
  input  wire logic [3:0]               wstrb,
  // AXI4-Lite write response
  output wire logic                     bvalid,
  input  wire logic                     bready,
  output wire logic [1:0]               bresp,
  // AXI4-Lite read address
  input  wire logic                     arvalid,
  output wire logic                     arready,
  input  wire logic [`FPS_ADDR_W-1:0]   araddr,
  input  wire logic [2:0]               arprot,
  // AXI4-Lite read data
  output wire logic                     rvalid,
  input  wire logic                     rready,
  output wire logic [31:0]              rdata,
  output wire logic [1:0]               rresp,
  // Mode and termination pins
  input  wire logic                     serial_prog_mode,
  input  wire logic                     op_abort,
  // Processor
  output wire logic                     cpu_stall,
  // Flash array
  output wire fps_pkg::fps_op_type      flash_op_kind,
  output wire logic [23:0]              flash_op_addr,
  output wire logic                     flash_op_start,
  output wire logic                     flash_word_we,
  output wire logic [4:0]               flash_word_idx,
  output wire logic [23:0]              flash_word_data
);

  // ==========================================================
  // Helpers
  function automatic logic [15:0] fps_merge(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0]  s);
    fps_merge = old;
    if (s[0]) fps_merge[7:0] = d[7:0];
    if (s[1]) fps_merge[15:8] = d[15:8];
  endfunction

  function automatic fps_pkg::fps_op_type fps_decode(input logic       er,
                                                     input logic [5:0] c,
                                                     input logic       ser);
    fps_decode = fps_pkg::FPS_OP_NONE;
    if (er) begin
      if (c[5:2] == 4'hA)
        fps_decode = ser ? fps_pkg::FPS_OP_ERASE_BOOT
                         : fps_pkg::FPS_OP_DENIED;
      else if (c[5:2] == 4'h9)
        fps_decode = ser ? fps_pkg::FPS_OP_ERASE_ALL
                         : fps_pkg::FPS_OP_DENIED;
      else if (c == 6'h1A)
        fps_decode = fps_pkg::FPS_OP_ERASE_ROW4;
      else if (c == 6'h19)
        fps_decode = fps_pkg::FPS_OP_ERASE_ROW2;
      else if (c == 6'h18)
        fps_decode = fps_pkg::FPS_OP_ERASE_ROW1;
      else if (c[5:2] == 4'h5)
        fps_decode = fps_pkg::FPS_OP_ERASE_CFG;
      else if (c[5:2] == 4'h4)
        fps_decode = fps_pkg::FPS_OP_ERASE_EE;
      else if (c[5:2] == 4'h3)
        fps_decode = fps_pkg::FPS_OP_ERASE_GEN;
    end else if (c[5:2] == 4'h1) begin
      fps_decode = fps_pkg::FPS_OP_WRITE_ROW;
    end
  endfunction

  // ==========================================================
  // Pin synchronisers
  logic [1:0] pin_s1_r;
  logic [1:0] pin_s2_r;
  logic [1:0] pin_raw;
  assign pin_raw = {op_abort, serial_prog_mode};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pin_s1_r[gi] <= 1'b0;
          pin_s2_r[gi] <= 1'b0;
        end else begin
          pin_s1_r[gi] <= pin_raw[gi];
          pin_s2_r[gi] <= pin_s1_r[gi];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Operation engine
  fps_op_if op_bus ();
  fps_op_engine u_engine (
    .aclk    (aclk),
    .aresetn (aresetn),
    .op      (op_bus.engine)
  );

  // ==========================================================
  // AXI4-Lite slave
  logic                   awgot_r, awgot_nxt;
  logic [`FPS_ADDR_W-1:0] awad_r, awad_nxt;
  logic                   wgot_r, wgot_nxt;
  logic [31:0]            wd_r, wd_nxt;
  logic [3:0]             ws_r, ws_nxt;
  logic                   bv_r, bv_nxt;
  logic [1:0]             br_r, br_nxt;
  logic                   rv_r, rv_nxt;
  logic [31:0]            rd_r, rd_nxt;
  logic [1:0]             rr_r, rr_nxt;
  logic                   wr_fire;
  logic                   wr_hit;

  // Control state
  logic                   wr_r, wr_nxt;
  logic                   wen_r, wen_nxt;
  logic                   err_r, err_nxt;
  logic                   pgm_r, pgm_nxt;
  logic                   ers_r, ers_nxt;
  logic [5:0]             code_r, code_nxt;
  logic [7:0]             page_r, page_nxt;
  logic [15:0]            ea_r, ea_nxt;
  fps_pkg::fps_key_type   key_r, key_nxt;
  fps_pkg::fps_op_type    kind_r, kind_nxt;
  logic [23:0]            addr_r, addr_nxt;
  logic                   start_r, start_nxt;
  logic                   lat_lo_we;
  logic                   lat_hi_we;
  logic [15:0]            ctl_rd;
  logic [15:0]            ctl_m;
  logic [23:0]            tptr;
  fps_pkg::fps_op_type    dec;

  // Holding latches
  logic [23:0]            latch_r [`FPS_ROW_WORDS];
  logic                   fwe_r;
  logic [4:0]             fidx_r;
  logic [23:0]            fdat_r;

  assign wr_fire = awgot_r && wgot_r && !bv_r;
  assign wr_hit  = (awad_r == `FPS_OFS_CONTROL) || (awad_r == `FPS_OFS_KEY)
                || (awad_r == `FPS_OFS_PAGE) || (awad_r == `FPS_OFS_EA)
                || (awad_r == `FPS_OFS_LATCH_LO)
                || (awad_r == `FPS_OFS_LATCH_HI);

  always_comb begin
    awgot_nxt = awgot_r;
    awad_nxt  = awad_r;
    wgot_nxt  = wgot_r;
    wd_nxt    = wd_r;
    ws_nxt    = ws_r;
    bv_nxt    = bv_r;
    br_nxt    = br_r;
    rv_nxt    = rv_r;
    rd_nxt    = rd_r;
    rr_nxt    = rr_r;
    if (awvalid && awready) begin
      awgot_nxt = 1'b1;
      awad_nxt  = awaddr;
    end
    if (wvalid && wready) begin
      wgot_nxt = 1'b1;
      wd_nxt   = wdata;
      ws_nxt   = wstrb;
    end
    if (wr_fire) begin
      awgot_nxt = 1'b0;
      wgot_nxt  = 1'b0;
      bv_nxt    = 1'b1;
      br_nxt    = wr_hit ? 2'h0 : 2'h2;
    end else if (bv_r && bready) begin
      bv_nxt = 1'b0;
    end
    if (arvalid && arready) begin
      rv_nxt = 1'b1;
      rr_nxt = 2'h0;
      unique case (araddr)
        `FPS_OFS_CONTROL: rd_nxt = {16'h0000, ctl_rd};
        `FPS_OFS_KEY:     rd_nxt = 32'h0000_0000;
        `FPS_OFS_PAGE:    rd_nxt = {24'h00_0000, page_r};
        `FPS_OFS_EA:      rd_nxt = {16'h0000, ea_r};
        `FPS_OFS_LATCH_LO,
        `FPS_OFS_LATCH_HI: rd_nxt = 32'h0000_0000;
        default: begin
          rd_nxt = 32'h0000_0000;
          rr_nxt = 2'h2;
        end
      endcase
    end else if (rv_r && rready) begin
      rv_nxt = 1'b0;
    end
  end

  // ==========================================================
  // Control register, unlock and trigger
  assign ctl_rd = {wr_r, wen_r, err_r, pgm_r, 5'h00, ers_r, code_r};
  assign ctl_m  = fps_merge(ctl_rd, wd_r, ws_r);
  assign tptr   = {page_r, ea_r};
  assign dec    = fps_decode(ctl_m[`FPS_BIT_ERASE], ctl_m[5:0], pin_s2_r[0]);

  always_comb begin
    wr_nxt    = wr_r;
    wen_nxt   = wen_r;
    err_nxt   = err_r;
    pgm_nxt   = pgm_r;
    ers_nxt   = ers_r;
    code_nxt  = code_r;
    page_nxt  = page_r;
    ea_nxt    = ea_r;
    key_nxt   = key_r;
    kind_nxt  = kind_r;
    addr_nxt  = addr_r;
    start_nxt = 1'b0;
    lat_lo_we = 1'b0;
    lat_hi_we = 1'b0;
    if (wr_fire) begin
      key_nxt = fps_pkg::FPS_KEY_LOCKED;
      if (awad_r == `FPS_OFS_KEY && ws_r[0]) begin
        if (wd_r[7:0] == `FPS_KEY_FIRST)
          key_nxt = fps_pkg::FPS_KEY_HALF;
        else if (key_r == fps_pkg::FPS_KEY_HALF
                 && wd_r[7:0] == `FPS_KEY_SECOND)
          key_nxt = fps_pkg::FPS_KEY_OPEN;
      end
      if (awad_r == `FPS_OFS_CONTROL && !wr_r) begin
        wen_nxt  = ctl_m[`FPS_BIT_WEN];
        err_nxt  = ctl_m[`FPS_BIT_ERR];
        pgm_nxt  = ctl_m[`FPS_BIT_PROG_ONLY];
        ers_nxt  = ctl_m[`FPS_BIT_ERASE];
        code_nxt = ctl_m[5:0];
        if (ctl_m[`FPS_BIT_WR]) begin
          if (key_r != fps_pkg::FPS_KEY_OPEN
              || !ctl_m[`FPS_BIT_WEN]
              || dec == fps_pkg::FPS_OP_DENIED) begin
            err_nxt = 1'b1;
          end else if (dec != fps_pkg::FPS_OP_NONE) begin
            wr_nxt    = 1'b1;
            err_nxt   = 1'b0;
            start_nxt = 1'b1;
            kind_nxt  = dec;
            unique case (dec)
              fps_pkg::FPS_OP_ERASE_ROW1,
              fps_pkg::FPS_OP_WRITE_ROW: addr_nxt = tptr & `FPS_ROW1_MASK;
              fps_pkg::FPS_OP_ERASE_ROW2: addr_nxt = tptr & `FPS_ROW2_MASK;
              fps_pkg::FPS_OP_ERASE_ROW4: addr_nxt = tptr & `FPS_ROW4_MASK;
              default: addr_nxt = tptr;
            endcase
          end
        end
      end
      if (awad_r == `FPS_OFS_PAGE)
        page_nxt = 8'(fps_merge({8'h00, page_r}, wd_r, ws_r));
      if (awad_r == `FPS_OFS_EA)
        ea_nxt = fps_merge(ea_r, wd_r, ws_r);
      if (!wr_r) begin
        lat_lo_we = (awad_r == `FPS_OFS_LATCH_LO);
        lat_hi_we = (awad_r == `FPS_OFS_LATCH_HI) && ws_r[0];
      end
    end
    if (op_bus.done || op_bus.aborted) begin
      wr_nxt = 1'b0;
      kind_nxt = fps_pkg::FPS_OP_NONE;
    end
    if (op_bus.aborted)
      err_nxt = 1'b1;
  end

  assign op_bus.start = start_r;
  assign op_bus.erase = (kind_r != fps_pkg::FPS_OP_WRITE_ROW);
  assign op_bus.abort = pin_s2_r[1];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awgot_r <= 1'b0;
      awad_r  <= '0;
      wgot_r  <= 1'b0;
      wd_r    <= 32'h0000_0000;
      ws_r    <= 4'h0;
      bv_r    <= 1'b0;
      br_r    <= 2'h0;
      rv_r    <= 1'b0;
      rd_r    <= 32'h0000_0000;
      rr_r    <= 2'h0;
      wr_r    <= 1'(`FPS_CTL_RESET >> `FPS_BIT_WR);
      wen_r   <= 1'b0;
      err_r   <= 1'b0;
      pgm_r   <= 1'b0;
      ers_r   <= 1'b0;
      code_r  <= 6'h00;
      page_r  <= 8'h00;
      ea_r    <= 16'h0000;
      key_r   <= fps_pkg::FPS_KEY_LOCKED;
      kind_r  <= fps_pkg::FPS_OP_NONE;
      addr_r  <= 24'h00_0000;
      start_r <= 1'b0;
    end else begin
      awgot_r <= awgot_nxt;
      awad_r  <= awad_nxt;
      wgot_r  <= wgot_nxt;
      wd_r    <= wd_nxt;
      ws_r    <= ws_nxt;
      bv_r    <= bv_nxt;
      br_r    <= br_nxt;
      rv_r    <= rv_nxt;
      rd_r    <= rd_nxt;
      rr_r    <= rr_nxt;
      wr_r    <= wr_nxt;
      wen_r   <= wen_nxt;
      err_r   <= err_nxt;
      pgm_r   <= pgm_nxt;
      ers_r   <= ers_nxt;
      code_r  <= code_nxt;
      page_r  <= page_nxt;
      ea_r    <= ea_nxt;
      key_r   <= key_nxt;
      kind_r  <= kind_nxt;
      addr_r  <= addr_nxt;
      start_r <= start_nxt;
    end
  end

  // ==========================================================
  // Holding latches and commit to the array
  always_ff @(posedge aclk) begin
    if (lat_lo_we)
      latch_r[ea_r[5:1]][15:0] <= fps_merge(latch_r[ea_r[5:1]][15:0],
                                            wd_r, ws_r);
    if (lat_hi_we)
      latch_r[ea_r[5:1]][23:16] <= wd_r[7:0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fwe_r  <= 1'b0;
      fidx_r <= 5'h00;
      fdat_r <= 24'h00_0000;
    end else begin
      fwe_r <= op_bus.word_req;
      if (op_bus.word_req) begin
        fidx_r <= op_bus.word_idx;
        fdat_r <= latch_r[op_bus.word_idx];
      end
    end
  end

  // ==========================================================
  // Outputs
  assign awready         = !awgot_r && !bv_r;
  assign wready          = !wgot_r && !bv_r;
  assign bvalid          = bv_r;
  assign bresp           = br_r;
  assign arready         = !rv_r;
  assign rvalid          = rv_r;
  assign rdata           = rd_r;
  assign rresp           = rr_r;
  assign cpu_stall       = wr_r;
  assign flash_op_kind   = kind_r;
  assign flash_op_addr   = addr_r;
  assign flash_op_start  = start_r;
  assign flash_word_we   = fwe_r;
  assign flash_word_idx  = fidx_r;
  assign flash_word_data = fdat_r;

endmodule

// ==== verif/fps_flash_seq_assertions.sv ====
`timescale 1ns/10ps
`include "fps_defs.svh"
// ====
// Sequencer checks
module fps_seq_chk (
  // Clock and reset
  input wire logic                    aclk,
  input wire logic                    aresetn,
  // AXI4-Lite bus
  input wire logic                    awvalid,
  input wire logic                    awready,
  input wire logic [`FPS_ADDR_W-1:0]  awaddr,
  input wire logic [2:0]              awprot,
  input wire logic                    wvalid,
  input wire logic                    wready,
  input wire logic [31:0]             wdata,
  input wire logic [3:0]              wstrb,
  input wire logic                    bvalid,
  input wire logic                    bready,
  input wire logic [1:0]              bresp,
  input wire logic                    arvalid,
  input wire logic                    arready,
  input wire logic [`FPS_ADDR_W-1:0]  araddr,
  input wire logic [2:0]              arprot,
  input wire logic                    rvalid,
  input wire logic                    rready,
  input wire logic [31:0]             rdata,
  input wire logic [1:0]              rresp,
  // Pins and flash side
  input wire logic                    serial_prog_mode,
  input wire logic                    op_abort,
  input wire logic                    cpu_stall,
  input wire fps_pkg::fps_op_type     flash_op_kind,
  input wire logic [23:0]             flash_op_addr,
  input wire logic                    flash_op_start,
  input wire logic                    flash_word_we,
  input wire logic [4:0]              flash_word_idx,
  input wire logic [23:0]             flash_word_data
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  start_stall_a:
    assert property (flash_op_start |-> cpu_stall)
    else $error("start without stall");
  stall_rise_a:
    assert property ($rose(cpu_stall) |-> flash_op_start)
    else $error("stall rose without start");
  start_pulse_a:
    assert property (flash_op_start |=> !flash_op_start)
    else $error("start pulse too long");
  op_hold_a:
    assert property (flash_op_start |=> cpu_stall [*8])
    else $error("operation ended too soon");
  word_kind_a:
    assert property (flash_word_we |-> cpu_stall &&
      flash_op_kind == fps_pkg::FPS_OP_WRITE_ROW)
    else $error("latch word outside row write");
  row_align_a:
    assert property (flash_op_start |->
      (flash_op_kind != fps_pkg::FPS_OP_ERASE_ROW1 ||
       flash_op_addr[5:0] == 6'h00) &&
      (flash_op_kind != fps_pkg::FPS_OP_ERASE_ROW4 ||
       flash_op_addr[7:0] == 8'h00))
    else $error("row address not aligned");
  serial_gate_a:
    assert property (flash_op_start &&
      (flash_op_kind == fps_pkg::FPS_OP_ERASE_BOOT ||
       flash_op_kind == fps_pkg::FPS_OP_ERASE_ALL)
      |-> $past(serial_prog_mode, 3))
    else $error("boot or full erase outside serial mode");
  rdata_hold_a:
    assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
endmodule

bind fps_flash_seq fps_seq_chk u_chk (.*);

// ==== verif/fps_flash_seq_tb.sv ====
`timescale 1ns/10ps
`include "fps_defs.svh"
module fps_flash_seq_tb;
  // ====
  // Signals
  logic aclk = '0;
  logic aresetn = '0;
  logic awvalid = '0, wvalid = '0, bready = '0;
  logic arvalid = '0, rready = '0;
  logic serial_prog_mode = '0, op_abort = '0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic cpu_stall, flash_op_start, flash_word_we;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd, ew;
  logic [23:0] flash_op_addr, flash_word_data, addr;
  logic [4:0] flash_word_idx;
  fps_pkg::fps_op_type flash_op_kind, kind;
  int n_mismatch = 0, checks_done = 0, n_we = 0, cyc;
  logic [15:0] ctl [12] = '{16'h4058, 16'h505A, 16'h4059, 16'h4057,
    16'h4052, 16'h404E, 16'h406B, 16'h4067, 16'h407F, 16'h4018,
    16'h4068, 16'h0058};
  fps_pkg::fps_op_type kd [12] = '{fps_pkg::FPS_OP_ERASE_ROW1,
    fps_pkg::FPS_OP_ERASE_ROW4, fps_pkg::FPS_OP_ERASE_ROW2,
    fps_pkg::FPS_OP_ERASE_CFG, fps_pkg::FPS_OP_ERASE_EE,
    fps_pkg::FPS_OP_ERASE_GEN, fps_pkg::FPS_OP_ERASE_BOOT,
    fps_pkg::FPS_OP_ERASE_ALL, fps_pkg::FPS_OP_NONE,
    fps_pkg::FPS_OP_NONE, fps_pkg::FPS_OP_NONE, fps_pkg::FPS_OP_NONE};
  logic [23:0] ad [8] = '{24'h1234C0, 24'h123400, 24'h123480,
    24'h1234D6, 24'h1234D6, 24'h1234D6, 24'h1234D6, 24'h1234D6};
  logic [11:0] er = 12'hC00;

  fps_flash_seq u_dut (.*);

  always #20 aclk = ~aclk;

  // ====
  // Tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw, ta, tw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= '1;
    wvalid <= '1;
    while (pa || pw) begin
      @(negedge aclk);
      ta = pa && awready;
      tw = pw && wready;
      @(posedge aclk);
      pa = pa && !ta;
      pw = pw && !tw;
      awvalid <= pa;
      wvalid <= pw;
    end
    @(posedge aclk);
    bready <= '1;
    do begin
      @(negedge aclk);
      ta = bvalid;
      resp = bresp;
      @(posedge aclk);
    end while (!ta);
    bready <= '0;
  endtask

  task automatic rdr(input logic [7:0] a);
    logic t;
    @(posedge aclk);
    araddr <= a;
    arvalid <= '1;
    do begin
      @(negedge aclk);
      t = arready;
      @(posedge aclk);
    end while (!t);
    arvalid <= '0;
    @(posedge aclk);
    rready <= '1;
    do begin
      @(negedge aclk);
      t = rvalid;
      rd = rdata;
      resp = rresp;
      @(posedge aclk);
    end while (!t);
    rready <= '0;
  endtask

  task automatic drain();
    while (cpu_stall === 1'b1) begin
      @(negedge aclk);
      cyc++;
    end
  endtask

  task automatic go(input logic [15:0] c, input bit w);
    wr(`FPS_OFS_CONTROL, {16'h0000, c});
    wr(`FPS_OFS_KEY, 32'h55);
    wr(`FPS_OFS_KEY, 32'hAA);
    wr(`FPS_OFS_CONTROL, {16'h0000, c | 16'h8000});
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    kind = flash_op_kind;
    addr = flash_op_addr;
    cyc = 0;
    if (w)
      drain();
  endtask

  // ====
  // Latch word monitor
  always @(negedge aclk)
    if (flash_word_we === 1'b1) begin
      n_we++;
      ew = 32'h401000 + 32'h10001 * flash_word_idx;
      chk({8'h00, flash_word_data}, ew);
    end

  // ====
  // Watchdog
  initial begin
    #1000000;
    n_mismatch++;
    end_of_test();
  end

  // ====
  // Tests
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= '1;
    rdr(`FPS_OFS_CONTROL);
    chk(rd, 32'h0);
    wr(`FPS_OFS_KEY, 32'h55);
    chk({30'h0, resp}, 32'h0);
    rdr(`FPS_OFS_KEY);
    chk(rd, 32'h0);
    wr(`FPS_OFS_CONTROL, 32'hC058);
    rdr(`FPS_OFS_CONTROL);
    chk(rd, 32'h6058);
    wr(`FPS_OFS_KEY, 32'h55);
    wr(`FPS_OFS_PAGE, 32'h12);
    wr(`FPS_OFS_KEY, 32'hAA);
    wr(`FPS_OFS_CONTROL, 32'hC058);
    rdr(`FPS_OFS_CONTROL);
    chk(rd & 32'hA000, 32'h2000);
    wr(`FPS_OFS_KEY, 32'h55);
    wr(`FPS_OFS_KEY, 32'hAA);
    wr(`FPS_OFS_EA, 32'h34D6);
    wr(`FPS_OFS_CONTROL, 32'hC058);
    rdr(`FPS_OFS_CONTROL);
    chk(rd & 32'hA000, 32'h2000);
    for (int i = 0; i < 12; i++) begin
      serial_prog_mode <= (i == 6 || i == 7);
      go(ctl[i], 1'b1);
      rdr(`FPS_OFS_CONTROL);
      chk({28'h0, kind}, {28'h0, kd[i]});
      chk(rd & 32'hA000, er[i] ? 32'h2000 : 32'h0);
      if (kd[i] == fps_pkg::FPS_OP_NONE)
        chk(32'(cyc), 32'h0);
      else
        chk(32'(cyc > 490 && cyc < 510), 32'h1);
      if (i < 8)
        chk({8'h00, addr}, {8'h00, ad[i]});
    end
    for (int i = 0; i < 32; i++) begin
      wr(`FPS_OFS_EA, 32'(2 * i));
      wr(`FPS_OFS_LATCH_LO, 32'h1000 + i);
      wr(`FPS_OFS_LATCH_HI, 32'h40 + i);
    end
    n_we = 0;
    go(16'h4004, 1'b1);
    chk({28'h0, kind}, {28'h0, fps_pkg::FPS_OP_WRITE_ROW});
    chk(32'(n_we), 32'h20);
    chk(32'(cyc > 90 && cyc < 110), 32'h1);
    go(16'h4058, 1'b0);
    wr(`FPS_OFS_CONTROL, 32'h0);
    rdr(`FPS_OFS_CONTROL);
    chk(rd & 32'hC000, 32'hC000);
    op_abort <= '1;
    drain();
    @(posedge aclk);
    op_abort <= '0;
    rdr(`FPS_OFS_CONTROL);
    chk(rd & 32'hA000, 32'h2000);
    chk(32'(cyc < 400), 32'h1);
    rdr(8'h40);
    chk({30'h0, resp}, 32'h2);
    chk(rd, 32'h0);
    wr(8'h40, 32'h0);
    chk({30'h0, resp}, 32'h2);
    end_of_test();
  end
endmodule
